// [rtl/rfs_consts.vh]
// constants for the rs485 fieldbus slave port: offsets, fields, resets, timing
`ifndef RFS_CONSTS_VH
`define RFS_CONSTS_VH
`define RFS_CLK_HZ 40000000
`define RFS_MS_CYC (`RFS_CLK_HZ / 1000)
`define RFS_OFF_CTRL 8'h00
`define RFS_OFF_PROTO 8'h04
`define RFS_OFF_BAUD 8'h08
`define RFS_OFF_ADDR 8'h0c
`define RFS_OFF_WORDS 8'h10
`define RFS_OFF_TRESP 8'h14
`define RFS_OFF_TCHAR 8'h18
`define RFS_OFF_TFRAME 8'h1c
`define RFS_OFF_PDTO 8'h20
`define RFS_OFF_FAULT 8'h24
`define RFS_OFF_STATUS 8'h28
`define RFS_OFF_MASK 8'h2c
`define RFS_OFF_RXDATA 8'h30
`define RFS_OFF_TXDATA 8'h34
`define RFS_OFF_RUNADDR 8'h38
`define RFS_PROTO_MODBUS 8'h02
`define RFS_RST_PROTO 8'h00
`define RFS_RST_BAUD 4'h7
`define RFS_RST_ADDR 8'h01
`define RFS_RST_PWC 4'h2
`define RFS_RST_PCWC 7'h04
`define RFS_PWC_MAX 4'h8
`define RFS_PCWC_VAR 7'h7f
`define RFS_DRV_ADDR_MAX 8'h1e
`define RFS_MB_ADDR_MAX 8'hf7
`define RFS_RST_TRESP 16'h0064
`define RFS_RST_TCHAR 16'h0021
`define RFS_RST_TFRAME 16'h004d
`define RFS_RST_PDTO 16'h0064
// half bits of one character, which the byte-to-byte gap count also spans
`define RFS_CHAR_HALVES 17'h00016
`define RFS_ST_RXBYTE 0
`define RFS_ST_FOK 1
`define RFS_ST_FBAD 2
`define RFS_ST_PDTO 3
`define RFS_ST_RLATE 4
`define RFS_ST_TXDONE 5
`define RFS_ST_TXOVR 6
`define RFS_NST 7
`define RFS_WORDS_PCWC_LSB 8
`define RFS_RUN_VALID_BIT 8
`define RFS_RUN_SWITCH_BIT 9
`define RFS_RUN_LOCK_BIT 10
`endif

// [rtl/rfs_char.v]
// one 11-bit character engine: start, 8 data lsb first, even parity, stop
`timescale 1ns/1ps
module rfs_char
(
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire [15:0] bit_div,
  input wire rxd,
  output reg rx_valid_q,
  output reg [7:0] rx_data_q,
  output reg rx_perr_q,
  input wire tx_start,
  input wire [7:0] tx_data,
  output wire tx_busy,
  output reg tx_done_q,
  output wire txd
);
  reg [15:0] rcnt_q;
  reg [3:0] rbit_q;
  reg rbusy_q;
  reg [9:0] rsh_q;
  reg [15:0] tcnt_q;
  reg [3:0] tbit_q;
  reg [10:0] tsh_q;

  assign tx_busy = (tbit_q != 4'h0);
  assign txd = tx_busy ? tsh_q[0] : 1'b1;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rcnt_q <= 16'h0000;
      rbit_q <= 4'h0;
      rbusy_q <= 1'b0;
      rsh_q <= 10'h000;
      rx_valid_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_perr_q <= 1'b0;
    end
    else if (ce)
    begin
      rx_valid_q <= 1'b0;
      if (!rbusy_q)
      begin
        // first sample lands mid-bit, so count half a bit before the start check
        if (!rxd)
        begin
          rbusy_q <= 1'b1;
          rcnt_q <= {1'b0, bit_div[15:1]};
          rbit_q <= 4'h0;
        end
      end
      else if (rcnt_q != 16'h0000)
        rcnt_q <= rcnt_q - 16'h0001;
      else
      begin
        rcnt_q <= bit_div - 16'h0001;
        if (rbit_q == 4'h0)
        begin
          if (rxd)
            rbusy_q <= 1'b0;
          else
            rbit_q <= 4'h1;
        end
        else if (rbit_q == 4'ha)
        begin
          rbusy_q <= 1'b0;
          rx_valid_q <= 1'b1;
          rx_data_q <= rsh_q[8:1];
          // parity over data and parity bit must be even; a low stop bit counts too
          rx_perr_q <= (^rsh_q[9:1]) | ~rxd;
        end
        else
        begin
          rsh_q <= {rxd, rsh_q[9:1]};
          rbit_q <= rbit_q + 4'h1;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tcnt_q <= 16'h0000;
      tbit_q <= 4'h0;
      tsh_q <= 11'h7ff;
      tx_done_q <= 1'b0;
    end
    else if (ce)
    begin
      tx_done_q <= 1'b0;
      if (!tx_busy)
      begin
        if (tx_start)
        begin
          tsh_q <= {1'b1, ^tx_data, tx_data, 1'b0};
          tbit_q <= 4'hb;
          tcnt_q <= bit_div - 16'h0001;
        end
      end
      else if (tcnt_q != 16'h0000)
        tcnt_q <= tcnt_q - 16'h0001;
      else
      begin
        tcnt_q <= bit_div - 16'h0001;
        tsh_q <= {1'b1, tsh_q[10:1]};
        tbit_q <= tbit_q - 4'h1;
        tx_done_q <= (tbit_q == 4'h1);
      end
    end
  end
endmodule // rfs_char

// [rtl/rfs_port.v]
// rs485 fieldbus slave port: apb registers, framing, address, supervision
`timescale 1ns/1ps
`include "rfs_consts.vh"
// Behaviour
// - serial protocol station addresses 1..30 only valid
// - process data words 0..8, sixteen bits each
// - parameter channel 0, 3, 4 words or variable
// - no process data within timeout flags fault
// - supervision default 100 ms raises alarm
// - slave only, start, 8 data, even parity, stop
// - modbus station addresses 1..247 valid, 0 invalid
// - valid switch address wins, setting locked
// - modbus setting used only with switches zero
// - reply due within response deadline, index 0
// - inter-character gap within character delay, index 1
// - inter-frame delay, index 2, ends frames
// - receive fault statistics readable
// - baud code selects line rate, default 19200
// - protocol select 2 means modbus framing
// - changed address applies only after restart
module rfs_port
#(
  parameter MS_CYC = `RFS_MS_CYC
)
(
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire rxd,
  output wire txd,
  output wire tx_drive_en,
  input wire [6:0] addr_switch,
  output wire pd_fault,
  output wire irq
);
  reg en_q;
  reg [7:0] proto_q;
  reg [3:0] baud_q;
  reg [7:0] addr_set_q;
  reg [3:0] pwc_q;
  reg [6:0] pcwc_q;
  reg [15:0] tresp_q;
  reg [15:0] tchar_q;
  reg [15:0] tframe_q;
  reg [15:0] pdto_q;
  reg [15:0] fault_q;
  reg [`RFS_NST-1:0] status_q;
  reg [`RFS_NST-1:0] mask_q;
  reg [7:0] rxdata_q;
  reg [7:0] run_addr_q;
  reg run_sw_q;
  reg [2:0] rx_s_q;
  reg rx_q;
  reg [6:0] sw_s1_q;
  reg [6:0] sw_s2_q;
  reg [6:0] sw_s3_q;
  reg [6:0] sw_q;
  reg [15:0] hcnt_q;
  reg [15:0] gap_q;
  reg in_frame_q;
  reg bad_q;
  reg addr_hit_q;
  reg [7:0] nbytes_q;
  reg [31:0] mcnt_q;
  reg [15:0] pd_ms_q;
  reg [15:0] rsp_ms_q;
  reg rsp_arm_q;
  reg pd_fault_q;
  reg [15:0] bit_div;
  reg [31:0] div_full;
  reg [`RFS_NST-1:0] ev;
  reg [31:0] rd_d;
  reg rd_err;
  wire modbus;
  wire wr;
  wire rd_setup;
  wire sw_valid;
  wire sw_zero;
  wire setting_locked;
  wire rx_valid;
  wire [7:0] rx_data;
  wire rx_perr;
  wire tx_busy;
  wire tx_done;
  wire tx_go;
  wire half_tick;
  wire ms_tick;
  wire frame_end;
  wire [7:0] expect_len;
  wire len_ok;
  wire [7:0] own_addr;

  assign modbus = (proto_q == `RFS_PROTO_MODBUS);
  assign pready = ce;
  assign wr = psel & penable & pwrite & ce;
  assign rd_setup = psel & ~penable & ce;
  assign tx_go = wr & (paddr == `RFS_OFF_TXDATA) & ~tx_busy;
  assign tx_drive_en = tx_busy;
  assign irq = |(status_q & mask_q);
  assign pd_fault = pd_fault_q;

  // switch validity follows the protocol's own address range
  assign sw_zero = (sw_q == 7'h00);
  assign sw_valid = modbus ? ~sw_zero :
    (~sw_zero && ({1'b0, sw_q} <= `RFS_DRV_ADDR_MAX));
  assign setting_locked = sw_valid;

  always @*
  begin
    case (baud_q)
      4'h4: div_full = `RFS_CLK_HZ / 2400;
      4'h5: div_full = `RFS_CLK_HZ / 4800;
      4'h6: div_full = `RFS_CLK_HZ / 9600;
      4'h7: div_full = `RFS_CLK_HZ / 19200;
      4'h8: div_full = `RFS_CLK_HZ / 38400;
      4'h9: div_full = `RFS_CLK_HZ / 57600;
      4'ha: div_full = `RFS_CLK_HZ / 76800;
      4'hb: div_full = `RFS_CLK_HZ / 93750;
      4'hc: div_full = `RFS_CLK_HZ / 115200;
      4'hd: div_full = `RFS_CLK_HZ / 187500;
      default: div_full = `RFS_CLK_HZ / 19200;
    endcase
    bit_div = div_full[15:0];
  end

  rfs_char u_char
  (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .bit_div(bit_div),
    .rxd(rx_q),
    .rx_valid_q(rx_valid),
    .rx_data_q(rx_data),
    .rx_perr_q(rx_perr),
    .tx_start(tx_go),
    .tx_data(pwdata[7:0]),
    .tx_busy(tx_busy),
    .tx_done_q(tx_done),
    .txd(txd)
  );

  // pin inputs: three stages, a change is taken once stages two and three agree
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_s_q <= 3'h7;
      rx_q <= 1'b1;
      sw_s1_q <= 7'h00;
      sw_s2_q <= 7'h00;
      sw_s3_q <= 7'h00;
      sw_q <= 7'h00;
    end
    else if (ce)
    begin
      rx_s_q <= {rx_s_q[1:0], rxd};
      if (rx_s_q[1] == rx_s_q[2])
        rx_q <= rx_s_q[2];
      sw_s1_q <= addr_switch;
      sw_s2_q <= sw_s1_q;
      sw_s3_q <= sw_s2_q;
      if (sw_s2_q == sw_s3_q)
        sw_q <= sw_s3_q;
    end
  end

  // running address is frozen when the port is first enabled and kept until reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_addr_q <= 8'h00;
      run_sw_q <= 1'b0;
    end
    else if (ce && !en_q && wr && paddr == `RFS_OFF_CTRL && pwdata[0])
    begin
      run_sw_q <= sw_valid;
      if (sw_valid)
        run_addr_q <= {1'b0, sw_q};
      else if (modbus && !sw_zero)
        run_addr_q <= 8'h00;
      else
        run_addr_q <= addr_set_q;
    end
  end

  assign own_addr = run_addr_q;
  wire run_valid = modbus ?
    (own_addr != 8'h00 && own_addr <= `RFS_MB_ADDR_MAX) :
    (own_addr != 8'h00 && own_addr <= `RFS_DRV_ADDR_MAX);

  // half-bit ticks time the gaps; millisecond ticks time the supervisions
  assign half_tick = (hcnt_q == 16'h0000);
  assign ms_tick = (mcnt_q == 32'h0);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hcnt_q <= 16'h0000;
      mcnt_q <= 32'h0;
    end
    else if (ce)
    begin
      hcnt_q <= half_tick ? ({1'b0, bit_div[15:1]} - 16'h0001) : hcnt_q - 16'h0001;
      mcnt_q <= ms_tick ? (MS_CYC - 1) : mcnt_q - 32'h1;
    end
  end

  // serial protocol telegram: start, length, address, words, check byte
  assign expect_len = 8'h04 + {3'h0, pwc_q, 1'b0} + {pcwc_q[6:0], 1'b0};
  assign len_ok = modbus || (pcwc_q == `RFS_PCWC_VAR) || (nbytes_q == expect_len);
  assign frame_end = in_frame_q & half_tick & (gap_q >= tframe_q);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap_q <= 16'h0000;
      in_frame_q <= 1'b0;
      bad_q <= 1'b0;
      addr_hit_q <= 1'b0;
      nbytes_q <= 8'h00;
      rxdata_q <= 8'h00;
    end
    else if (ce)
    begin
      if (rx_valid)
      begin
        gap_q <= 16'h0000;
        rxdata_q <= rx_data;
        in_frame_q <= 1'b1;
        if (nbytes_q != 8'hff)
          nbytes_q <= nbytes_q + 8'h01;
        if (rx_perr)
          bad_q <= 1'b1;
        if (in_frame_q && {1'b0, gap_q} > {1'b0, tchar_q} + `RFS_CHAR_HALVES)
          bad_q <= 1'b1;
        if ((modbus && nbytes_q == 8'h00) || (!modbus && nbytes_q == 8'h02))
          addr_hit_q <= modbus ? (rx_data == own_addr) : ({3'h0, rx_data[4:0]} == own_addr);
      end
      else if (frame_end)
      begin
        in_frame_q <= 1'b0;
        bad_q <= 1'b0;
        addr_hit_q <= 1'b0;
        nbytes_q <= 8'h00;
      end
      else if (half_tick && gap_q != 16'hffff)
        gap_q <= gap_q + 16'h0001;
    end
  end

  wire frame_good = frame_end & ~bad_q & len_ok & addr_hit_q & run_valid & en_q;
  wire frame_bad = frame_end & (bad_q | ~len_ok);
  wire pd_arrival = frame_good & (modbus | (pwc_q != 4'h0));

  // process data supervision and reply deadline, both in milliseconds
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pd_ms_q <= 16'h0000;
      pd_fault_q <= 1'b0;
      rsp_ms_q <= 16'h0000;
      rsp_arm_q <= 1'b0;
      fault_q <= 16'h0000;
    end
    else if (ce)
    begin
      if (pd_arrival || pdto_q == 16'h0000 || !en_q)
      begin
        pd_ms_q <= 16'h0000;
        pd_fault_q <= 1'b0;
      end
      else if (ms_tick && !pd_fault_q)
      begin
        pd_ms_q <= pd_ms_q + 16'h0001;
        if (pd_ms_q + 16'h0001 >= pdto_q)
          pd_fault_q <= 1'b1;
      end
      if (frame_good)
      begin
        rsp_arm_q <= 1'b1;
        rsp_ms_q <= 16'h0000;
      end
      else if (tx_go || (rsp_arm_q && ms_tick && rsp_ms_q + 16'h0001 >= tresp_q))
        rsp_arm_q <= 1'b0;
      else if (rsp_arm_q && ms_tick)
        rsp_ms_q <= rsp_ms_q + 16'h0001;
      if (frame_bad && fault_q != 16'hffff)
        fault_q <= fault_q + 16'h0001;
    end
  end

  wire rsp_late = rsp_arm_q & ms_tick & ~frame_good & ~tx_go &
    (tresp_q != 16'h0000) & (rsp_ms_q + 16'h0001 >= tresp_q);

  always @*
  begin
    ev = {`RFS_NST{1'b0}};
    ev[`RFS_ST_RXBYTE] = rx_valid;
    ev[`RFS_ST_FOK] = frame_good;
    ev[`RFS_ST_FBAD] = frame_bad;
    ev[`RFS_ST_PDTO] = pd_fault_q & ~status_q[`RFS_ST_PDTO];
    ev[`RFS_ST_RLATE] = rsp_late;
    ev[`RFS_ST_TXDONE] = tx_done;
    ev[`RFS_ST_TXOVR] = wr & (paddr == `RFS_OFF_TXDATA) & tx_busy;
  end

  // register writes; status clears by writing one, a same-cycle event wins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q <= 1'b0;
      proto_q <= `RFS_RST_PROTO;
      baud_q <= `RFS_RST_BAUD;
      addr_set_q <= `RFS_RST_ADDR;
      pwc_q <= `RFS_RST_PWC;
      pcwc_q <= `RFS_RST_PCWC;
      tresp_q <= `RFS_RST_TRESP;
      tchar_q <= `RFS_RST_TCHAR;
      tframe_q <= `RFS_RST_TFRAME;
      pdto_q <= `RFS_RST_PDTO;
      status_q <= {`RFS_NST{1'b0}};
      mask_q <= {`RFS_NST{1'b0}};
    end
    else if (ce)
    begin
      status_q <= (status_q & ~((wr && paddr == `RFS_OFF_STATUS) ?
        pwdata[`RFS_NST-1:0] : {`RFS_NST{1'b0}})) | ev;
      if (wr)
      begin
        case (paddr)
          `RFS_OFF_CTRL: en_q <= en_q | pwdata[0];
          `RFS_OFF_PROTO: proto_q <= pwdata[7:0];
          `RFS_OFF_BAUD:
            if (pwdata[3:0] >= 4'h4 && pwdata[3:0] <= 4'hd)
              baud_q <= pwdata[3:0];
          `RFS_OFF_ADDR:
            if (!setting_locked)
              addr_set_q <= pwdata[7:0];
          `RFS_OFF_WORDS:
          begin
            if (pwdata[3:0] <= `RFS_PWC_MAX)
              pwc_q <= pwdata[3:0];
            if (pwdata[14:8] == 7'h00 || pwdata[14:8] == 7'h03 ||
                pwdata[14:8] == 7'h04 || pwdata[14:8] == `RFS_PCWC_VAR)
              pcwc_q <= pwdata[14:8];
          end
          `RFS_OFF_TRESP: tresp_q <= pwdata[15:0];
          `RFS_OFF_TCHAR: tchar_q <= pwdata[15:0];
          `RFS_OFF_TFRAME: tframe_q <= pwdata[15:0];
          `RFS_OFF_PDTO: pdto_q <= pwdata[15:0];
          `RFS_OFF_MASK: mask_q <= pwdata[`RFS_NST-1:0];
          default: en_q <= en_q;
        endcase
      end
    end
  end

  always @*
  begin
    rd_d = 32'h0;
    rd_err = 1'b0;
    case (paddr)
      `RFS_OFF_CTRL: rd_d = {31'h0, en_q};
      `RFS_OFF_PROTO: rd_d = {24'h0, proto_q};
      `RFS_OFF_BAUD: rd_d = {28'h0, baud_q};
      `RFS_OFF_ADDR: rd_d = {24'h0, addr_set_q};
      `RFS_OFF_WORDS: rd_d = {17'h0, pcwc_q, 4'h0, pwc_q};
      `RFS_OFF_TRESP: rd_d = {16'h0, tresp_q};
      `RFS_OFF_TCHAR: rd_d = {16'h0, tchar_q};
      `RFS_OFF_TFRAME: rd_d = {16'h0, tframe_q};
      `RFS_OFF_PDTO: rd_d = {16'h0, pdto_q};
      `RFS_OFF_FAULT: rd_d = {16'h0, fault_q};
      `RFS_OFF_STATUS: rd_d = {25'h0, status_q};
      `RFS_OFF_MASK: rd_d = {25'h0, mask_q};
      `RFS_OFF_RXDATA: rd_d = {24'h0, rxdata_q};
      `RFS_OFF_TXDATA: rd_d = 32'h0;
      `RFS_OFF_RUNADDR: rd_d = {21'h0, en_q, setting_locked, run_valid, run_addr_q};
      default: rd_err = 1'b1;
    endcase
  end

  // read data is captured in the setup cycle so the access phase needs no wait
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (rd_setup)
    begin
      prdata <= pwrite ? 32'h0 : rd_d;
      pslverr <= rd_err;
    end
  end
endmodule // rfs_port

// [verification/rfs_master_model.sv]
// bus master model that sends characters on the rs485 receive line
`timescale 1ns/1ps
module rfs_master_model
#(
  parameter int BIT = 213
)
(
  input wire logic pclk,
  output logic rxd
);
  // the bias resistors pull the idle line high
  initial rxd = 1'h1;
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // bad_par flips the parity bit so the slave must reject the frame
  task automatic send_char(input logic [7:0] d, input logic bad_par);
    logic [10:0] f;
    f = {1'h1, (^d) ^ bad_par, d, 1'h0};
    for (int i = 0; i < 11; i++)
    begin
      rxd <= f[i];
      wait_cyc(BIT);
    end
  endtask
  // two characters, then idle past 3.5 characters so the frame closes
  task automatic send_frame(input logic [7:0] a, input logic [7:0] b, input logic bad_par,
                            input int gap);
    send_char(a, 1'h0);
    wait_cyc(gap);
    send_char(b, bad_par);
    wait_cyc(BIT * 40);
  endtask
endmodule // rfs_master_model

// [verification/rfs_port_chk.sv]
// assertion checker watching the pins of the fieldbus slave port
`timescale 1ns/1ps
`include "rfs_consts.vh"
module rfs_port_chk
#(
  parameter MS_CYC = 40
)
(
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rxd,
  input wire txd,
  input wire tx_drive_en,
  input wire [6:0] addr_switch,
  input wire pd_fault,
  input wire irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence bad_setup_s;
    psel && !penable && paddr > `RFS_OFF_RUNADDR;
  endsequence
  sequence good_setup_s;
    psel && !penable && paddr <= `RFS_OFF_RUNADDR && paddr[1:0] == 2'h0;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  ready_ce_a: assert property (psel && penable |-> pready == ce)
    else $error("pready does not follow ce");
  unmapped_err_a: assert property (bad_setup_s ##1 access_s |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (good_setup_s ##1 access_s |-> !pslverr)
    else $error("mapped access refused");
  rdata_hold_a: assert property (access_s ##1 !psel |-> $stable(prdata) && $stable(pslverr))
    else $error("read data did not stand");
  txd_idle_a: assert property (!tx_drive_en |-> txd)
    else $error("line not idle high");
  start_bit_a: assert property ($rose(tx_drive_en) |-> (!txd && tx_drive_en)[*8])
    else $error("start bit missing");
  stop_bit_a: assert property ($fell(tx_drive_en) |-> $past(txd))
    else $error("stop bit not high");
  reset_out_a: assert property ($rose(presetn) |-> txd && !tx_drive_en && !pd_fault && !irq)
    else $error("outputs wrong after reset");
endmodule // rfs_port_chk

// [verification/tb_top.sv]
// self-checking testbench for the rs485 fieldbus slave port
`timescale 1ns/1ps
`include "rfs_consts.vh"
module tb_top;
  localparam int BIT = 213;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, rxd, txd, tx_drive_en;
  logic pd_fault, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [6:0] addr_switch;
  int n_fail, checks;
  rfs_port #(.MS_CYC(40)) i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_drive_en(tx_drive_en),
    .addr_switch(addr_switch), .pd_fault(pd_fault), .irq(irq));
  rfs_master_model #(.BIT(BIT)) i_mst (.pclk(pclk), .rxd(rxd));
  initial
  begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rv = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rv & m);
  endtask
  task automatic do_reset;
    presetn <= 1'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
  endtask
  task automatic t_regs;
    rdc("baud", `RFS_OFF_BAUD, 32'h7, ALL);
    rdc("addr", `RFS_OFF_ADDR, 32'h1, ALL);
    rdc("words", `RFS_OFF_WORDS, 32'h402, ALL);
    rdc("tresp", `RFS_OFF_TRESP, 32'h64, ALL);
    rdc("tchar", `RFS_OFF_TCHAR, 32'h21, ALL);
    rdc("tframe", `RFS_OFF_TFRAME, 32'h4d, ALL);
    rdc("pdto", `RFS_OFF_PDTO, 32'h64, ALL);
    rdc("fault", `RFS_OFF_FAULT, 32'h0, ALL);
    apb(1'h1, `RFS_OFF_BAUD, 32'h3);
    rdc("baud low", `RFS_OFF_BAUD, 32'h7, ALL);
    apb(1'h1, `RFS_OFF_BAUD, 32'he);
    rdc("baud high", `RFS_OFF_BAUD, 32'h7, ALL);
    apb(1'h1, `RFS_OFF_WORDS, 32'h409);
    rdc("pwc 9", `RFS_OFF_WORDS, 32'h402, ALL);
    apb(1'h1, `RFS_OFF_WORDS, 32'h508);
    rdc("pcwc 5", `RFS_OFF_WORDS, 32'h408, ALL);
    apb(1'h1, `RFS_OFF_WORDS, 32'h7f08);
    rdc("pcwc var", `RFS_OFF_WORDS, 32'h7f08, ALL);
    apb(1'h0, 8'h3c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rv);
    $display("test regs done");
  endtask
  task automatic t_addr;
    logic [6:0] sw [5];
    logic [7:0] pr [5];
    logic [7:0] st [5];
    logic [31:0] ex [5];
    sw = '{7'h00, 7'h00, 7'h14, 7'h28, 7'h00};
    pr = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h00};
    st = '{8'h00, 8'hf7, 8'h05, 8'h05, 8'h1f};
    ex = '{32'h400, 32'h5f7, 32'h714, 32'h505, 32'h400};
    for (int i = 0; i < 5; i++)
    begin
      addr_switch <= sw[i];
      do_reset();
      repeat (5) @(posedge pclk);
      apb(1'h1, `RFS_OFF_PROTO, {24'h0, pr[i]});
      apb(1'h1, `RFS_OFF_ADDR, {24'h0, st[i]});
      apb(1'h1, `RFS_OFF_CTRL, 32'h1);
      rdc("run addr", `RFS_OFF_RUNADDR, ex[i], ex[i][8] ? ALL : 32'h700);
      rdc("addr lock", `RFS_OFF_ADDR, (i == 2) ? 32'h1 : {24'h0, st[i]}, ALL);
      apb(1'h1, `RFS_OFF_ADDR, 32'h9);
      rdc("run kept", `RFS_OFF_RUNADDR, ex[i], ex[i][8] ? ALL : 32'h700);
    end
    $display("test addr done");
  endtask
  task automatic t_frames;
    logic [10:0] f;
    f = {1'h1, ^8'ha5, 8'ha5, 1'h0};
    addr_switch <= 7'h00;
    do_reset();
    apb(1'h1, `RFS_OFF_PROTO, 32'h2);
    apb(1'h1, `RFS_OFF_ADDR, 32'h5);
    apb(1'h1, `RFS_OFF_BAUD, 32'hd);
    apb(1'h1, `RFS_OFF_MASK, 32'h2);
    apb(1'h1, `RFS_OFF_CTRL, 32'h1);
    i_mst.send_frame(8'h05, 8'h01, 1'h0, 0);
    rdc("frame ok", `RFS_OFF_STATUS, 32'h2, 32'h6);
    chk("irq on", 32'h1, {31'h0, irq});
    rdc("rx byte", `RFS_OFF_RXDATA, 32'h1, ALL);
    apb(1'h1, `RFS_OFF_TXDATA, 32'ha5);
    apb(1'h1, `RFS_OFF_TXDATA, 32'h3c);
    repeat (BIT / 2 - 6) @(posedge pclk);
    for (int i = 0; i < 11; i++)
    begin
      chk("tx bit", {31'h0, f[i]}, {31'h0, txd});
      chk("tx en", 32'h1, {31'h0, tx_drive_en});
      repeat (BIT) @(posedge pclk);
    end
    chk("tx idle", 32'h1, {31'h0, txd & ~tx_drive_en});
    rdc("tx status", `RFS_OFF_STATUS, 32'h60, 32'h70);
    apb(1'h1, `RFS_OFF_PDTO, 32'h0);
    apb(1'h1, `RFS_OFF_STATUS, ALL);
    chk("irq off", 32'h0, {31'h0, irq});
    i_mst.send_frame(8'h05, 8'h01, 1'h1, 0);
    rdc("parity fault", `RFS_OFF_FAULT, 32'h1, ALL);
    rdc("parity status", `RFS_OFF_STATUS, 32'h4, 32'h6);
    chk("irq masked", 32'h0, {31'h0, irq});
    i_mst.send_frame(8'h05, 8'h01, 1'h0, BIT * 25);
    rdc("gap fault", `RFS_OFF_FAULT, 32'h2, ALL);
    chk("pd off", 32'h0, {31'h0, pd_fault});
    apb(1'h1, `RFS_OFF_STATUS, ALL);
    apb(1'h1, `RFS_OFF_TRESP, 32'h1);
    apb(1'h1, `RFS_OFF_PDTO, 32'h2);
    i_mst.send_frame(8'h05, 8'h01, 1'h0, 0);
    rdc("late status", `RFS_OFF_STATUS, 32'h1a, 32'h1e);
    chk("pd fault", 32'h1, {31'h0, pd_fault});
    apb(1'h1, `RFS_OFF_PROTO, 32'h0);
    apb(1'h1, `RFS_OFF_WORDS, 32'h0);
    i_mst.send_frame(8'h05, 8'h01, 1'h0, 0);
    rdc("short frame", `RFS_OFF_FAULT, 32'h3, ALL);
    $display("test frames done");
  endtask
  task automatic give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    presetn = 1'h0;
    ce = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    addr_switch = 7'h0;
    n_fail = 0;
    checks = 0;
    do_reset();
    t_regs();
    t_addr();
    t_frames();
    give_verdict();
  end
  // the five frames need about 70000 cycles
  initial
  begin
    repeat (90000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end
endmodule // tb_top
bind rfs_port rfs_port_chk #(.MS_CYC(MS_CYC)) i_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
  .tx_drive_en(tx_drive_en), .addr_switch(addr_switch), .pd_fault(pd_fault), .irq(irq));
